// ==== common/t3c_pkg.sv ====
// shared constants and types for the lower timer stage control block
package t3c_pkg;
   // register indices; byte address is four times the index
   localparam logic [7:0] T3C_IDX_TIMER3_CONTROL = 8'h1A;
   localparam logic [7:0] T3C_IDX_UPPER_STAGE_CONTROL = 8'h1B;
   localparam logic [7:0] T3C_IDX_SYSTEM_CONFIG = 8'h1C;
   localparam logic [7:0] T3C_IDX_STATUS = 8'h1D;
   localparam int T3C_ADDR_W = 8;
   localparam int T3C_DATA_W = 32;

   // control register field positions (both stages share the layout)
   localparam int T3C_FF_BIT = 7;
   localparam int T3C_SEL_HI = 6;
   localparam int T3C_SEL_LO = 4;
   localparam int T3C_RUN_BIT = 3;
   localparam int T3C_MODE_HI = 2;
   localparam int T3C_MODE_LO = 0;

   // system config field positions
   localparam int T3C_CFG_PRESCALE_BIT = 0;
   localparam int T3C_CFG_SLOW_BIT = 1;

   // status field positions
   localparam int T3C_ST_RUN_BIT = 0;
   localparam int T3C_ST_FF_BIT = 1;
   localparam int T3C_ST_CASCADE_BIT = 2;
   localparam int T3C_ST_EXT_BIT = 3;
   localparam int T3C_ST_LOW_BIT = 4;

   // reset values
   localparam logic [7:0] T3C_CONTROL_RESET = 8'h00;
   localparam logic [7:0] T3C_CONFIG_RESET = 8'h00;

   // source select codes
   localparam logic [2:0] T3C_SEL_DIV2048 = 3'h0;
   localparam logic [2:0] T3C_SEL_DIV128 = 3'h1;
   localparam logic [2:0] T3C_SEL_DIV32 = 3'h2;
   localparam logic [2:0] T3C_SEL_DIV8 = 3'h3;
   localparam logic [2:0] T3C_SEL_LOW = 3'h4;
   localparam logic [2:0] T3C_SEL_DIV2 = 3'h5;
   localparam logic [2:0] T3C_SEL_HIGH = 3'h6;
   localparam logic [2:0] T3C_SEL_PIN = 3'h7;

   // prescaler exponents, index order 2,8,32,128,2048
   localparam int T3C_NUM_DIV = 5;
   localparam int T3C_DIV_EXP [T3C_NUM_DIV] = '{1, 3, 5, 7, 11};
   localparam int T3C_PRESCALE_W = 11;
   // low clock divided by 2^3 in the slow/alternate option
   localparam int T3C_LOW_DIV_W = 3;

   // lower mode field codes
   localparam logic [2:0] T3C_MODE_TIMER = 3'h0;
   localparam logic [2:0] T3C_MODE_DIVIDER = 3'h1;
   localparam logic [2:0] T3C_MODE_PWM = 3'h2;
   localparam logic [2:0] T3C_MODE_CASCADE = 3'h3;

   typedef enum logic [2:0] {
      T3C_OP_TIMER,
      T3C_OP_DIVIDER,
      T3C_OP_PWM,
      T3C_OP_CASCADE,
      T3C_OP_RESERVED
   } t3c_op_type;
endpackage : t3c_pkg

// ==== core/t3c_source_mux.sv ====
// source clock prescaler, pin synchronisers and source select mux
`timescale 1ns/1ps
module t3c_source_mux (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic [2:0] lower_source_select,
   input wire logic prescaler_low_clock_option,
   input wire logic slow_mode,
   input wire logic low_clock_pin,
   input wire logic ext_count_pin,
   output logic source_tick,
   output logic low_clock_level,
   output logic ext_pin_level
);
   import t3c_pkg::*;

   logic [T3C_PRESCALE_W-1:0] prescale;
   logic [T3C_NUM_DIV-1:0] div_tick;
   logic [2:0] sync_a [2];
   logic [1:0] level;
   logic [1:0] rise;
   logic [T3C_LOW_DIV_W-1:0] low_div;
   logic low_div_tick;
   logic next_tick;

   // high clock is mclk itself; a free counter gives every high clock division
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         prescale <= '0;
      end else begin
         prescale <= prescale + 1'b1;
      end
   end

   genvar g;
   generate
      for (g = 0; g < T3C_NUM_DIV; g++) begin : g_div
         assign div_tick[g] = &prescale[T3C_DIV_EXP[g]-1:0];
      end
      // index 0 low clock pin, index 1 external count pin
      for (g = 0; g < 2; g++) begin : g_sync
         always_ff @(posedge mclk) begin
            if (sys_rst) begin
               sync_a[g] <= 3'h0;
               level[g] <= 1'b0;
               rise[g] <= 1'b0;
            end else begin
               sync_a[g] <= {sync_a[g][1:0], (g == 0) ? low_clock_pin : ext_count_pin};
               // first stage only feeds the second; stages two and three must agree
               rise[g] <= 1'b0;
               if (sync_a[g][1] == sync_a[g][2] && sync_a[g][2] != level[g]) begin
                  level[g] <= sync_a[g][2];
                  rise[g] <= sync_a[g][2];
               end
            end
         end
      end
   endgenerate

   assign low_clock_level = level[0];
   assign ext_pin_level = level[1];

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         low_div <= '0;
      end else if (rise[0]) begin
         low_div <= low_div + 1'b1;
      end
   end
   assign low_div_tick = rise[0] & (&low_div);

   // in slow/sleep only the low clock options, the external count pin and the warm-up high clock exist
   always_comb begin
      next_tick = 1'b0;
      case (lower_source_select)
         T3C_SEL_DIV2048: begin
            next_tick = (prescaler_low_clock_option | slow_mode) ? low_div_tick : div_tick[4];
         end
         T3C_SEL_DIV128: next_tick = ~slow_mode & div_tick[3];
         T3C_SEL_DIV32: next_tick = ~slow_mode & div_tick[2];
         T3C_SEL_DIV8: next_tick = ~slow_mode & div_tick[1];
         T3C_SEL_LOW: next_tick = rise[0];
         T3C_SEL_DIV2: next_tick = ~slow_mode & div_tick[0];
         T3C_SEL_HIGH: next_tick = 1'b1;
         T3C_SEL_PIN: next_tick = rise[1];
         default: next_tick = 1'b0;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         source_tick <= 1'b0;
      end else begin
         source_tick <= next_tick;
      end
   end
endmodule : t3c_source_mux

// ==== core/t3c_control.sv ====
// lower timer stage control register, cascade steering and register bus slave
//
// Register access over Avalon-MM was decided locally.
`timescale 1ns/1ps
module t3c_control #(
   parameter int ADDR_W = t3c_pkg::T3C_ADDR_W,
   parameter int DATA_W = t3c_pkg::T3C_DATA_W
) (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic [ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [DATA_W-1:0] avs_writedata,
   input wire logic [DATA_W/8-1:0] avs_byteenable,
   output logic [DATA_W-1:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic low_clock_pin,
   input wire logic ext_count_pin,
   input wire logic ff_toggle,
   output logic count_enable,
   output logic counter_clear,
   output logic output_flipflop,
   output logic cascade_active,
   output t3c_pkg::t3c_op_type lower_op,
   output logic [2:0] upper_mode_field
);
   import t3c_pkg::*;

   logic [7:0] timer3_control;
   logic [7:0] upper_stage_control;
   logic [7:0] system_config;
   logic ack;
   logic bus_req;
   logic bus_write_now;
   logic [7:0] word_index;
   logic word_aligned;
   logic [7:0] status_value;
   logic effective_run;
   logic effective_ff_ctl;
   logic run_prev;
   logic source_tick;
   logic low_clock_level;
   logic ext_pin_level;

   wire logic [2:0] lower_source_select = timer3_control[T3C_SEL_HI:T3C_SEL_LO];
   wire logic [2:0] lower_mode_field = timer3_control[T3C_MODE_HI:T3C_MODE_LO];
   wire logic lower_run_bit = timer3_control[T3C_RUN_BIT];
   wire logic lower_output_flipflop_ctl = timer3_control[T3C_FF_BIT];
   wire logic upper_run_bit = upper_stage_control[T3C_RUN_BIT];
   wire logic upper_output_flipflop_ctl = upper_stage_control[T3C_FF_BIT];
   wire logic prescaler_low_clock_option = system_config[T3C_CFG_PRESCALE_BIT];
   wire logic slow_mode = system_config[T3C_CFG_SLOW_BIT];

   function automatic t3c_op_type decode_mode(input logic [2:0] mode);
      t3c_op_type op;
      op = T3C_OP_RESERVED;
      if (mode == T3C_MODE_TIMER) begin
         op = T3C_OP_TIMER;
      end else if (mode == T3C_MODE_DIVIDER) begin
         op = T3C_OP_DIVIDER;
      end else if (mode == T3C_MODE_PWM) begin
         op = T3C_OP_PWM;
      end else if (mode == T3C_MODE_CASCADE) begin
         op = T3C_OP_CASCADE;
      end
      return op;
   endfunction : decode_mode

   // bus slave: one wait cycle, then the answer
   assign bus_req = avs_read | avs_write;
   assign avs_waitrequest = bus_req & ~ack;
   assign bus_write_now = avs_write & ack & avs_byteenable[0];
   assign word_aligned = (avs_address[1:0] == 2'b00);
   assign word_index = 8'(avs_address >> 2);

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         ack <= 1'b0;
      end else begin
         ack <= bus_req & ~ack;
      end
   end

   // fields are written together; the upper stage sub-mode lives in its own register
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         timer3_control <= T3C_CONTROL_RESET;
      end else if (bus_write_now && word_aligned && word_index == T3C_IDX_TIMER3_CONTROL) begin
         // no field locking while running; software keeps to the usage limits
         timer3_control <= avs_writedata[7:0];
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         upper_stage_control <= T3C_CONTROL_RESET;
      end else if (bus_write_now && word_aligned && word_index == T3C_IDX_UPPER_STAGE_CONTROL) begin
         upper_stage_control <= avs_writedata[7:0];
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         system_config <= T3C_CONFIG_RESET;
      end else if (bus_write_now && word_aligned && word_index == T3C_IDX_SYSTEM_CONFIG) begin
         system_config <= {6'h00, avs_writedata[1:0]};
      end
   end

   always_comb begin
      status_value = 8'h00;
      status_value[T3C_ST_RUN_BIT] = effective_run;
      status_value[T3C_ST_FF_BIT] = output_flipflop;
      status_value[T3C_ST_CASCADE_BIT] = cascade_active;
      status_value[T3C_ST_EXT_BIT] = ext_pin_level;
      status_value[T3C_ST_LOW_BIT] = low_clock_level;
   end

   // unmapped or misaligned reads answer zero
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         avs_readdata <= '0;
      end else if (avs_read && !ack) begin
         if (!word_aligned) begin
            avs_readdata <= '0;
         end else if (word_index == T3C_IDX_TIMER3_CONTROL) begin
            avs_readdata <= DATA_W'(timer3_control);
         end else if (word_index == T3C_IDX_UPPER_STAGE_CONTROL) begin
            avs_readdata <= DATA_W'(upper_stage_control);
         end else if (word_index == T3C_IDX_SYSTEM_CONFIG) begin
            avs_readdata <= DATA_W'(system_config);
         end else if (word_index == T3C_IDX_STATUS) begin
            avs_readdata <= DATA_W'(status_value);
         end else begin
            avs_readdata <= '0;
         end
      end
   end

   // cascade: lower mode 011 hands run and flip-flop control to the upper stage
   always_comb begin
      if (decode_mode(lower_mode_field) == T3C_OP_CASCADE) begin
         effective_run = upper_run_bit;
         effective_ff_ctl = upper_output_flipflop_ctl;
      end else begin
         effective_run = lower_run_bit;
         effective_ff_ctl = lower_output_flipflop_ctl;
      end
   end

   // source select stays with the lower stage in both cases
   t3c_source_mux u_source_mux (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .lower_source_select(lower_source_select),
      .prescaler_low_clock_option(prescaler_low_clock_option),
      .slow_mode(slow_mode),
      .low_clock_pin(low_clock_pin),
      .ext_count_pin(ext_count_pin),
      .source_tick(source_tick),
      .low_clock_level(low_clock_level),
      .ext_pin_level(ext_pin_level)
   );

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         count_enable <= 1'b0;
         counter_clear <= 1'b1;
      end else begin
         count_enable <= effective_run & source_tick;
         counter_clear <= ~effective_run;
      end
   end

   // preset only on the start edge; a toggle in the same cycle loses to the preset
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         run_prev <= 1'b0;
         output_flipflop <= 1'b0;
      end else begin
         run_prev <= effective_run;
         if (effective_run && !run_prev) begin
            output_flipflop <= effective_ff_ctl;
         end else if (effective_run && ff_toggle) begin
            output_flipflop <= ~output_flipflop;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         cascade_active <= 1'b0;
         lower_op <= T3C_OP_TIMER;
         upper_mode_field <= 3'h0;
      end else begin
         cascade_active <= (decode_mode(lower_mode_field) == T3C_OP_CASCADE);
         lower_op <= decode_mode(lower_mode_field);
         upper_mode_field <= upper_stage_control[T3C_MODE_HI:T3C_MODE_LO];
      end
   end
endmodule : t3c_control

// ==== test/t3c_control_monitor.sv ====
// port checker for the lower timer stage control block
`timescale 1ns/1ps
module t3c_control_monitor #(
   parameter int ADDR_W = t3c_pkg::T3C_ADDR_W,
   parameter int DATA_W = t3c_pkg::T3C_DATA_W
) (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic [ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [DATA_W-1:0] avs_writedata,
   input wire logic [DATA_W/8-1:0] avs_byteenable,
   input wire logic [DATA_W-1:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic low_clock_pin,
   input wire logic ext_count_pin,
   input wire logic ff_toggle,
   input wire logic count_enable,
   input wire logic counter_clear,
   input wire logic output_flipflop,
   input wire logic cascade_active,
   input wire t3c_pkg::t3c_op_type lower_op,
   input wire logic [2:0] upper_mode_field
);
   import t3c_pkg::*;
   logic wr_ctl;
   // write to the lower control register at the edge it takes effect
   assign wr_ctl = avs_write & ~avs_waitrequest & avs_byteenable[0]
      & (avs_address == ADDR_W'({T3C_IDX_TIMER3_CONTROL, 2'b00}))
      & (avs_writedata[2:0] != T3C_MODE_CASCADE);
   default clocking @(posedge mclk); endclocking
   default disable iff (sys_rst);
   rst_state_a: assert property (
      $fell(sys_rst) |-> counter_clear && !output_flipflop && !cascade_active)
      else $error("outputs not at reset state");
   wait_ack_a: assert property (
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("bus answer late");
   read_high_a: assert property (
      avs_read && !avs_waitrequest |-> avs_readdata[DATA_W-1:8] == '0)
      else $error("read data upper bits set");
   // register lands at the write edge, outputs follow one edge later
   stop_clear_a: assert property (
      wr_ctl && !avs_writedata[T3C_RUN_BIT] |-> ##2 counter_clear)
      else $error("stop did not clear");
   start_preset_a: assert property (
      wr_ctl && counter_clear && avs_writedata[T3C_RUN_BIT]
      |-> ##2 !counter_clear && output_flipflop == $past(avs_writedata[T3C_FF_BIT], 2))
      else $error("start preset wrong");
   clear_count_a: assert property (counter_clear [*3] |-> !count_enable)
      else $error("count while cleared");
   // writes excluded: a run change may land in the same cycle as the pulse
   toggle_run_a: assert property (
      ff_toggle && !counter_clear && !avs_write && !$past(avs_write)
      |=> output_flipflop != $past(output_flipflop))
      else $error("toggle lost");
   cascade_dec_a: assert property (
      cascade_active == (lower_op == T3C_OP_CASCADE))
      else $error("cascade flag mismatch");
   cover property (wr_ctl && avs_writedata[T3C_RUN_BIT]);
   cover property (cascade_active && !counter_clear);
   cover property (count_enable);
endmodule : t3c_control_monitor

bind t3c_control t3c_control_monitor #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) mon_inst (
   .mclk(mclk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
   .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .low_clock_pin(low_clock_pin), .ext_count_pin(ext_count_pin), .ff_toggle(ff_toggle),
   .count_enable(count_enable), .counter_clear(counter_clear),
   .output_flipflop(output_flipflop), .cascade_active(cascade_active),
   .lower_op(lower_op), .upper_mode_field(upper_mode_field));

// ==== test/tb_timer3_control_and_cascade.sv ====
// self-checking bench for the lower timer stage control block
`timescale 1ns/1ps
module tb_timer3_control_and_cascade;
   import t3c_pkg::*;
   localparam logic [7:0] A_LO = 8'h68;
   localparam logic [7:0] A_UP = 8'h6C;
   localparam logic [7:0] A_CFG = 8'h70;
   localparam logic [7:0] A_ST = 8'h74;
   logic mclk = 1'b0;
   logic sys_rst = 1'b1;
   logic [7:0] avs_address = 8'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0] avs_byteenable = 4'h0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic [7:0] pins = 8'h00;
   logic ff_toggle = 1'b0;
   logic count_enable, counter_clear, output_flipflop, cascade_active;
   t3c_op_type lower_op;
   logic [2:0] upper_mode_field;
   int failures = 0;
   int cmp_count = 0;
   int tsel [10] = '{6, 5, 3, 2, 1, 0, 4, 7, 0, 5};
   // slow runs never pick the undivided high clock
   int tcfg [10] = '{0, 0, 0, 0, 0, 0, 0, 0, 1, 2};
   int texp [10] = '{256, 128, 32, 8, 2, 0, 16, 8, 2, 0};
   always #20 mclk = ~mclk;
   // low clock pin period 16 cycles, count pin period 32
   always @(posedge mclk) pins <= pins + 8'h01;
   t3c_control t3c_control_inst (
      .mclk(mclk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .low_clock_pin(pins[3]), .ext_count_pin(pins[4]), .ff_toggle(ff_toggle),
      .count_enable(count_enable), .counter_clear(counter_clear),
      .output_flipflop(output_flipflop), .cascade_active(cascade_active),
      .lower_op(lower_op), .upper_mode_field(upper_mode_field));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      cmp_count++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR %0t: %s seen %0h want %0h", $time, msg, seen, exp);
      end
   endtask : chk
   task automatic conclude;
      if (failures == 0 && cmp_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : conclude
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
   endtask : tick
   // request held until waitrequest is seen low at a rising edge
   task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
         input logic [3:0] be, output logic [31:0] q);
      @(posedge mclk);
      avs_address <= a;
      avs_writedata <= {24'h0, d};
      avs_byteenable <= be;
      avs_write <= w;
      avs_read <= ~w;
      do @(posedge mclk); while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask : bus
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, 4'h1, q);
   endtask : wr
   task automatic count(input int c, output int n);
      n = 0;
      repeat (c) begin
         @(posedge mclk);
         n += int'(count_enable);
      end
   endtask : count
   task automatic pulse;
      @(posedge mclk);
      ff_toggle <= 1'b1;
      @(posedge mclk);
      ff_toggle <= 1'b0;
      tick(2);
   endtask : pulse
   task automatic t_reset;
      logic [31:0] q;
      chk(32'(counter_clear), 1, "clear");
      chk(32'(output_flipflop), 0, "ff");
      bus(1'b0, A_LO, 8'h00, 4'hF, q);
      chk(q, 0, "ctl reset");
      bus(1'b0, 8'h69, 8'h00, 4'hF, q);
      chk(q, 0, "misaligned");
      wr(8'h78, 8'hFF);
      bus(1'b0, 8'h78, 8'h00, 4'hF, q);
      chk(q, 0, "unmapped");
   endtask : t_reset
   task automatic t_modes;
      logic [31:0] q;
      for (int m = 0; m < 8; m++) begin
         wr(A_LO, 8'(m));
         tick(2);
         chk(32'(lower_op), (m < 4) ? 32'(m) : 32'(T3C_OP_RESERVED), "mode");
         chk(32'(cascade_active), 32'(m == 3), "cascade");
         bus(1'b0, A_LO, 8'h00, 4'hF, q);
         chk(q, 32'(m), "readback");
      end
   endtask : t_modes
   task automatic t_sources;
      int n;
      for (int i = 0; i < 10; i++) begin
         wr(A_CFG, 8'(tcfg[i]));
         wr(A_LO, {1'b0, 3'(tsel[i]), 4'h8});
         tick(8);
         count(256, n);
         chk(32'(n + 1 >= texp[i] && n <= texp[i] + 1), 1, "rate");
         wr(A_LO, {1'b0, 3'(tsel[i]), 4'h0});
         tick(3);
         count(16, n);
         chk(32'(counter_clear), 1, "stop");
         chk(32'(n), 0, "idle count");
      end
      wr(A_CFG, 8'h00);
   endtask : t_sources
   task automatic t_start;
      wr(A_LO, 8'h88);
      tick(2);
      chk(32'(output_flipflop), 1, "preset set");
      chk(32'(counter_clear), 0, "run");
      pulse();
      chk(32'(output_flipflop), 0, "toggle");
      wr(A_LO, 8'h80);
      pulse();
      chk(32'(output_flipflop), 0, "stopped toggle");
      wr(A_LO, 8'h88);
      tick(2);
      chk(32'(output_flipflop), 1, "preset again");
      wr(A_LO, 8'h80);
      wr(A_LO, 8'h08);
      tick(2);
      chk(32'(output_flipflop), 0, "preset clear");
      wr(A_LO, 8'h00);
   endtask : t_start
   task automatic t_cascade;
      logic [31:0] q;
      int n;
      // no period or pulse-width writes anywhere while running
      wr(A_LO, 8'h63);
      wr(A_UP, 8'h8C);
      tick(8);
      count(32, n);
      chk(32'(n), 32, "lower source");
      chk(32'(counter_clear), 0, "upper run");
      chk(32'(output_flipflop), 1, "upper ff");
      chk(32'(upper_mode_field), 4, "upper mode");
      bus(1'b0, A_ST, 8'h00, 4'hF, q);
      chk(q & 32'h7, 7, "status");
      wr(A_UP, 8'h84);
      wr(A_LO, 8'h6B);
      tick(3);
      chk(32'(counter_clear), 1, "lower run ignored");
      wr(A_ST, 8'hFF);
      bus(1'b1, A_UP, 8'hFF, 4'h0, q);
      bus(1'b0, A_UP, 8'h00, 4'hF, q);
      chk(q, 32'h84, "byte disabled");
      bus(1'b0, A_ST, 8'h00, 4'hF, q);
      chk(q & 32'h5, 4, "status ro");
   endtask : t_cascade
   initial begin
      repeat (4) @(posedge mclk);
      sys_rst <= 1'b0;
      tick(1);
      t_reset();
      t_modes();
      t_sources();
      t_start();
      t_cascade();
      conclude();
   end
   // about 3100 cycles expected; generous margin
   initial begin
      repeat (20000) @(posedge mclk);
      failures++;
      $display("ERROR %0t: watchdog expired", $time);
      conclude();
   end
endmodule : tb_timer3_control_and_cascade
